// File: ebc_bus_ctrl.sv
// External bus controller: registers, area decode and DRAM control.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
//Contract
// [RQ1] Word SRAM pair decodes to area 1, 0x200000 to 0x23FFFF.
// [RQ2] Width bit 0 makes the area a 16-bit bus space.
// [RQ3] Access state bit 1 makes the area a 3-state space.
// [RQ4] Area 1 wait bits both 0 insert no program wait.
// [RQ5] Area 2 wait field 01 inserts exactly one program wait.
// [RQ6] Partition bit 1 gives eight 2-Mbyte areas.
// [RQ7] DRAM select 001 makes area 2 DRAM, 0x400000 to 0x47FFFF.
// [RQ8] Two column strobes control upper and lower DRAM bytes.
// [RQ9] Lower strobe goes to own pin at 0, write-strobe pin at 1.
// [RQ10] Memory control bits set precharge, page, shift, refresh modes.
// [RQ11] Refresh wait bit 0 adds no refresh wait states.
// [RQ12] DRAM control sets refresh on, no interrupt, clock divided two.
// [RQ13] Software loads refresh constant 0x4F for 1024 cycles per 8 ms.
// [RQ14] Row-down mode by bit 1, not with lower strobe on write pin.
// [RQ15] Counter match sets flag, clears counter, requests one refresh.
module ebc_bus_ctrl
	import ebc_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic [23:0] cpu_addr_i,
	input  wire logic        cpu_req_i,
	output logic             sram_cs_o,
	output logic             dram_sel_o,
	output logic             bus16_o,
	output logic             three_state_o,
	output logic      [1:0]  wait_states_o,
	input  wire logic        byte_hi_i,
	input  wire logic        byte_lo_i,
	input  wire logic        cas_active_i,
	input  wire logic        refresh_ack_i,
	output logic             upper_cas_n_o,
	output logic             lower_column_strobe_n_o,
	output logic             lower_write_strobe_cas_n_o,
	output logic             lws_is_cas_o,
	output logic      [3:0]  row_shift_o,
	output logic             precharge_two_o,
	output logic             fast_page_o,
	output logic             row_down_o,
	output logic      [1:0]  refresh_wait_o,
	output logic             refresh_req_o,
	output logic             cmp_irq_o
);
	import ebc_pkg::*;

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [7:0] width_q, state_q, wch_q, wcl_q, bch_q, bcl_q, mem_q;
	logic [7:0] dram_q, const_q, count;
	logic       flag_q, match;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			width_q <= RST_AREA_BUS_WIDTH;
			state_q <= RST_AREA_ACCESS_STATE;
			wch_q   <= RST_WAIT_CTRL;
			wcl_q   <= RST_WAIT_CTRL;
			bch_q   <= RST_ZERO;
			bcl_q   <= RST_ZERO;
			mem_q   <= RST_ZERO;
			dram_q  <= RST_ZERO;
			const_q <= RST_REFRESH_CONST;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				OFS_AREA_BUS_WIDTH:    width_q <= reg_wdata_i;
				OFS_AREA_ACCESS_STATE: state_q <= reg_wdata_i;
				OFS_WAIT_CTRL_HIGH:    wch_q   <= reg_wdata_i;
				OFS_WAIT_CTRL_LOW:     wcl_q   <= reg_wdata_i;
				OFS_BUS_CTRL_HIGH:     bch_q   <= reg_wdata_i;
				OFS_BUS_CTRL_LOW:      bcl_q   <= reg_wdata_i;
				OFS_MEMORY_CTRL:       mem_q   <= reg_wdata_i;
				OFS_DRAM_CTRL:         dram_q  <= reg_wdata_i;
				OFS_REFRESH_CONST:     const_q <= reg_wdata_i; // [RQ13]
				default:               ;
			endcase
		end
	end

	// Compare-match flag: hardware set wins over a software write of 0.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
			flag_q <= 1'b0;
		else if (match)
			flag_q <= 1'b1; // [RQ15]
		else if (reg_wr_i && reg_addr_i == OFS_DRAM_CTRL
			&& !reg_wdata_i[BIT_CMP_FLAG])
			flag_q <= 1'b0;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				OFS_AREA_BUS_WIDTH:    reg_rdata_o <= width_q;
				OFS_AREA_ACCESS_STATE: reg_rdata_o <= state_q;
				OFS_WAIT_CTRL_HIGH:    reg_rdata_o <= wch_q;
				OFS_WAIT_CTRL_LOW:     reg_rdata_o <= wcl_q;
				OFS_BUS_CTRL_HIGH:     reg_rdata_o <= bch_q;
				OFS_BUS_CTRL_LOW:      reg_rdata_o <= bcl_q;
				OFS_MEMORY_CTRL:       reg_rdata_o <= mem_q;
				OFS_DRAM_CTRL:
					reg_rdata_o <= {dram_q[7:5], flag_q, dram_q[3:0]};
				OFS_REFRESH_CONST:     reg_rdata_o <= const_q;
				OFS_REFRESH_COUNT:     reg_rdata_o <= count;
				default:               reg_rdata_o <= 8'h00;
			endcase
		end
		else
			reg_rdata_o <= 8'h00;
	end

	// ****************************************************************
	// Area decode
	// ****************************************************************
	logic [2:0] area;
	logic       dram_area2;
	logic       bus16, three_state;
	logic [1:0] wait_sel;

	ebc_area_decode u_decode (
		.addr_i        (cpu_addr_i),
		.part_sel_i    (bcl_q[BIT_PARTITION_SEL]),
		.width_reg_i   (width_q),
		.state_reg_i   (state_q),
		.wait_reg_i    ({wch_q, wcl_q}),
		.area_o        (area),
		.bus16_o       (bus16),
		.three_state_o (three_state),
		.wait_o        (wait_sel)
	);

	assign dram_area2 = (bch_q[2:0] == DRAM_SPACE_AREA2); // [RQ7]

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			sram_cs_o     <= 1'b0;
			dram_sel_o    <= 1'b0;
			bus16_o       <= 1'b0;
			three_state_o <= 1'b0;
			wait_states_o <= 2'h0;
		end
		else
		begin
			// Both memories sit in the 2-Mbyte area map only; the
			// 128-kbyte map would alias them into other addresses.
			// Word SRAM fills the low 256 kbytes of area 1.
			sram_cs_o <= cpu_req_i && area == 3'h1
				&& bcl_q[BIT_PARTITION_SEL]
				&& cpu_addr_i[20:0] < SRAM_BYTES[20:0]; // [RQ1]
			// DRAM fills the low 512 kbytes of area 2.
			dram_sel_o <= cpu_req_i && dram_area2 && area == 3'h2
				&& bcl_q[BIT_PARTITION_SEL]
				&& cpu_addr_i[20:0] < DRAM_BYTES[20:0]; // [RQ7]
			bus16_o       <= bus16;
			three_state_o <= three_state;
			wait_states_o <= wait_sel; // [RQ4] [RQ5]
		end
	end

	// ****************************************************************
	// DRAM strobes and mode
	// ****************************************************************
	logic lws_cas, cas_lo, cas_hi;

	assign lws_cas = bcl_q[BIT_LOW_CAS_SEL];
	assign cas_hi  = cas_active_i && (byte_hi_i || refresh_ack_i);
	assign cas_lo  = cas_active_i && (byte_lo_i || refresh_ack_i);

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			upper_cas_n_o              <= 1'b1;
			lower_column_strobe_n_o    <= 1'b1;
			lower_write_strobe_cas_n_o <= 1'b1;
		end
		else
		begin
			upper_cas_n_o              <= ~cas_hi; // [RQ8]
			lower_column_strobe_n_o    <= ~(cas_lo && !lws_cas); // [RQ9]
			lower_write_strobe_cas_n_o <= ~(cas_lo && lws_cas);  // [RQ9]
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			lws_is_cas_o    <= 1'b0;
			row_shift_o     <= 4'h0;
			precharge_two_o <= 1'b0;
			fast_page_o     <= 1'b0;
			row_down_o      <= 1'b0;
			refresh_wait_o  <= 2'h0;
		end
		else
		begin
			lws_is_cas_o    <= lws_cas;
			row_shift_o     <= 4'(PAGE_COL_BITS - 1)
				+ {2'b00, mem_q[BIT_MUX_HI], mem_q[BIT_MUX_LO]}; // [RQ10]
			precharge_two_o <= mem_q[BIT_PRECHARGE];          // [RQ10]
			fast_page_o     <= mem_q[BIT_FAST_PAGE];          // [RQ10]
			row_down_o      <= mem_q[BIT_ROW_DOWN] && !lws_cas; // [RQ14]
			refresh_wait_o  <= dram_q[BIT_RFSH_CYC_WAIT]
				? mem_q[BIT_RFSH_WAIT_HI:BIT_RFSH_WAIT_LO]
				: 2'h0; // [RQ11]
		end
	end

	// ****************************************************************
	// Refresh pacing
	// ****************************************************************
	ebc_refresh_timer u_timer (
		.sys_clk_i  (sys_clk_i),
		.rstn_i     (rstn_i),
		.enable_i   (dram_q[BIT_RFSH_EN]),
		.clk_sel_i  (dram_q[2:0]),
		.constant_i (const_q),
		.count_o    (count),
		.match_o    (match)
	);

	// One refresh request pends until the cycle is acknowledged.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
			refresh_req_o <= 1'b0;
		else if (match && !dram_q[BIT_RFSH_MODE])
			refresh_req_o <= 1'b1; // [RQ12] [RQ15]
		else if (refresh_ack_i)
			refresh_req_o <= 1'b0;
	end

	assign cmp_irq_o = flag_q && dram_q[BIT_CMP_IRQ_EN]; // [RQ12]

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_flag_set;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		match |=> flag_q;
	endproperty
	a_flag_set: assert property (p_flag_set) // [RQ15]
		else $error("match did not set flag");

	property p_req_set;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		(match && !dram_q[BIT_RFSH_MODE]) |=> refresh_req_o;
	endproperty
	a_req_set: assert property (p_req_set) // [RQ15]
		else $error("match did not request refresh");

	property p_count_clear;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		match |=> count == 8'h00;
	endproperty
	a_count_clear: assert property (p_count_clear) // [RQ15]
		else $error("counter not cleared on match");

	property p_lower_route;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		$past(lws_cas) && $past(rstn_i) |-> lower_column_strobe_n_o;
	endproperty
	a_lower_route: assert property (p_lower_route) // [RQ9]
		else $error("lower strobe on wrong pin");

	property p_row_down;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		lws_cas ##1 lws_cas |-> !row_down_o;
	endproperty
	a_row_down: assert property (p_row_down) // [RQ14]
		else $error("row-down with lower strobe on write pin");

	property p_sram_range;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		sram_cs_o |-> $past(cpu_addr_i) >= 24'h200000
			&& $past(cpu_addr_i) <= 24'h23FFFF;
	endproperty
	a_sram_range: assert property (p_sram_range) // [RQ1]
		else $error("SRAM select outside range");

	property p_dram_range;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		dram_sel_o |-> $past(cpu_addr_i) >= 24'h400000
			&& $past(cpu_addr_i) <= 24'h47FFFF;
	endproperty
	a_dram_range: assert property (p_dram_range) // [RQ7]
		else $error("DRAM select outside range");

	property p_no_rfsh_wait;
		@(posedge sys_clk_i) disable iff (!rstn_i)
		!dram_q[BIT_RFSH_CYC_WAIT] ##1 1'b1 |-> refresh_wait_o == 2'h0;
	endproperty
	a_no_rfsh_wait: assert property (p_no_rfsh_wait) // [RQ11]
		else $error("refresh wait inserted while disabled");

	c_refresh: cover property (@(posedge sys_clk_i) refresh_req_o);
	c_sram: cover property (@(posedge sys_clk_i) sram_cs_o);
	c_dram_lws: cover property (@(posedge sys_clk_i)
		dram_sel_o && lws_is_cas_o);
endmodule
`default_nettype wire

// File: ebc_pkg.sv
// Package of register offsets, field positions, reset values and timing.
package ebc_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [3:0] OFS_AREA_BUS_WIDTH    = 4'h0;
	localparam logic [3:0] OFS_AREA_ACCESS_STATE = 4'h1;
	localparam logic [3:0] OFS_WAIT_CTRL_HIGH    = 4'h2;
	localparam logic [3:0] OFS_WAIT_CTRL_LOW     = 4'h3;
	localparam logic [3:0] OFS_BUS_CTRL_HIGH     = 4'h4;
	localparam logic [3:0] OFS_BUS_CTRL_LOW      = 4'h5;
	localparam logic [3:0] OFS_MEMORY_CTRL       = 4'h6;
	localparam logic [3:0] OFS_DRAM_CTRL         = 4'h7;
	localparam logic [3:0] OFS_REFRESH_CONST     = 4'h8;
	localparam logic [3:0] OFS_REFRESH_COUNT     = 4'h9;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_AREA_BUS_WIDTH    = 8'h00;
	localparam logic [7:0] RST_AREA_ACCESS_STATE = 8'hFF;
	localparam logic [7:0] RST_WAIT_CTRL         = 8'hFF;
	localparam logic [7:0] RST_ZERO              = 8'h00;
	localparam logic [7:0] RST_REFRESH_CONST     = 8'hFF;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_PARTITION_SEL  = 2;
	localparam int BIT_LOW_CAS_SEL    = 4;
	localparam int BIT_PRECHARGE      = 7;
	localparam int BIT_FAST_PAGE      = 6;
	localparam int BIT_ROW_DOWN       = 5;
	localparam int BIT_TWO_CAS        = 4;
	localparam int BIT_MUX_HI         = 3;
	localparam int BIT_MUX_LO         = 2;
	localparam int BIT_RFSH_WAIT_HI   = 1;
	localparam int BIT_RFSH_WAIT_LO   = 0;
	localparam int BIT_RFSH_EN        = 7;
	localparam int BIT_RFSH_CYC_WAIT  = 6;
	localparam int BIT_RFSH_MODE      = 5;
	localparam int BIT_CMP_FLAG       = 4;
	localparam int BIT_CMP_IRQ_EN     = 3;

	// ****************************************************************
	// Address map and mode codes
	// ****************************************************************
	localparam logic [2:0] DRAM_SPACE_AREA2 = 3'h1;
	localparam logic [2:0] CLK_DIV2         = 3'h1;
	localparam logic [2:0] CLK_DIV8         = 3'h2;
	localparam logic [2:0] CLK_DIV32        = 3'h3;
	localparam logic [23:0] DRAM_BYTES      = 24'h080000;
	localparam logic [23:0] SRAM_BYTES      = 24'h040000;
	localparam int PAGE_COL_BITS            = 9;

	typedef enum logic [1:0] {EBC_SZ_AREA2M, EBC_SZ_AREA128K}
		ebc_part_t;

endpackage

// File: ebc_area_decode.sv
// Area decoder mapping a 24-bit address to an area and its settings.
`timescale 1ns/1ps
`default_nettype none
module ebc_area_decode
	import ebc_pkg::*;
(
	input  wire logic [23:0] addr_i,
	input  wire logic        part_sel_i,
	input  wire logic [7:0]  width_reg_i,
	input  wire logic [7:0]  state_reg_i,
	input  wire logic [15:0] wait_reg_i,
	output logic      [2:0]  area_o,
	output logic             bus16_o,
	output logic             three_state_o,
	output logic      [1:0]  wait_o
);
	always_comb
	begin
		// Eight 2-Mbyte areas or eight 128-kbyte areas.
		if (part_sel_i)
			area_o = addr_i[23:21]; // [RQ6]
		else
			area_o = addr_i[19:17];
		bus16_o       = ~width_reg_i[area_o]; // [RQ2]
		three_state_o = state_reg_i[area_o];  // [RQ3]
		wait_o        = wait_reg_i[{area_o, 1'b0} +: 2]; // [RQ4] [RQ5]
	end
endmodule
`default_nettype wire

// File: ebc_refresh_timer.sv
// Refresh pacing counter with clock prescaler and compare match.
`timescale 1ns/1ps
`default_nettype none
module ebc_refresh_timer
	import ebc_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	input  wire logic       enable_i,
	input  wire logic [2:0] clk_sel_i,
	input  wire logic [7:0] constant_i,
	output logic      [7:0] count_o,
	output logic            match_o
);
	logic [4:0] pre_q;
	logic       tick;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
			pre_q <= 5'h00;
		else
			pre_q <= pre_q + 5'h01;
	end

	always_comb
	begin
		case (clk_sel_i)
			CLK_DIV2:  tick = pre_q[0];        // [RQ12]
			CLK_DIV8:  tick = &pre_q[2:0];
			CLK_DIV32: tick = &pre_q[4:0];
			default:   tick = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i || !enable_i)
			count_o <= 8'h00;
		else if (tick && count_o == constant_i)
			count_o <= 8'h00; // [RQ15]
		else if (tick)
			count_o <= count_o + 8'h01;
	end

	assign match_o = enable_i && tick && (count_o == constant_i); // [RQ15]
endmodule
`default_nettype wire

// File: ebc_rfsh_partner.sv
// Model of the far-side refresh sequencer that answers refresh requests.
`timescale 1ns/1ps
`default_nettype none
module ebc_rfsh_partner
(
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	input  wire logic       req_i,
	input  wire logic [3:0] dly_i,
	output logic            ack_o
);
	logic [3:0] wait_q;

	// ****************************************************************
	// Acknowledge
	// ****************************************************************
	// One acknowledge per request, dly_i + 1 cycles after it, so prompt and slow
	// answers can both be exercised.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i || !req_i || ack_o)
		begin
			wait_q <= 4'h0;
			ack_o  <= 1'b0;
		end
		else
		begin
			wait_q <= wait_q + 4'h1;
			ack_o  <= (wait_q >= dly_i);
		end
	end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the external bus controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ebc_pkg::*;
	logic        sys_clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [3:0]  reg_addr_i = 4'h0;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [23:0] cpu_addr_i = 24'h000000;
	logic        cpu_req_i = 1'b0;
	logic        byte_hi_i = 1'b0;
	logic        byte_lo_i = 1'b0;
	logic        cas_active_i = 1'b0;
	logic [3:0]  dly = 4'h2;
	logic        refresh_ack_i;
	logic [7:0]  reg_rdata_o;
	logic [3:0]  row_shift_o;
	logic [1:0]  wait_states_o, refresh_wait_o;
	logic        sram_cs_o, dram_sel_o, bus16_o, three_state_o;
	logic        upper_cas_n_o, lower_column_strobe_n_o, lws_is_cas_o;
	logic        lower_write_strobe_cas_n_o, precharge_two_o, fast_page_o;
	logic        row_down_o, refresh_req_o, cmp_irq_o;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          t0, t1;
	logic [7:0]  rstv [10] = '{RST_AREA_BUS_WIDTH, RST_AREA_ACCESS_STATE,
		RST_WAIT_CTRL, RST_WAIT_CTRL, RST_ZERO, RST_ZERO, RST_ZERO,
		RST_ZERO, RST_REFRESH_CONST, RST_ZERO};

	ebc_bus_ctrl u_dut (.sys_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .cpu_addr_i, .cpu_req_i,
		.sram_cs_o, .dram_sel_o, .bus16_o, .three_state_o, .wait_states_o,
		.byte_hi_i, .byte_lo_i, .cas_active_i, .refresh_ack_i,
		.upper_cas_n_o, .lower_column_strobe_n_o,
		.lower_write_strobe_cas_n_o, .lws_is_cas_o, .row_shift_o,
		.precharge_two_o, .fast_page_o, .row_down_o, .refresh_wait_o,
		.refresh_req_o, .cmp_irq_o);
	ebc_rfsh_partner u_rfsh (.sys_clk_i, .rstn_i, .req_i(refresh_req_o),
		.dly_i(dly), .ack_o(refresh_ack_i));

	initial forever #10 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) cyc <= cyc + 1;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: seen %0h expected %0h", $time,
				seen, exp);
		end
	endtask
	task automatic settle;
		repeat (3) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, e);
	endtask
	task automatic dec(input logic [23:0] a, input logic cs, dr, w16, st,
		input logic [1:0] ws);
		@(posedge sys_clk_i);
		cpu_addr_i <= a;
		cpu_req_i  <= 1'b1;
		settle();
		chk(sram_cs_o, cs);
		chk(dram_sel_o, dr);
		chk(bus16_o, w16);
		chk(three_state_o, st);
		chk(wait_states_o, ws);
	endtask
	task automatic wait_lvl(input logic v, output int t);
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk_i);
			#1 n++;
		end while (refresh_req_o !== v && n < 400);
		if (n >= 400) error_cnt++;
		t = cyc;
	endtask
	task automatic end_sim;
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#200000;
		error_cnt++;
		end_sim();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		repeat (2) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 10; i++) rdc(i[3:0], rstv[i]);
		@(posedge sys_clk_i);
		#1 chk(reg_rdata_o, 8'h00);
		for (int i = 0; i < 9; i++)
		begin
			if (i != 7) wr(i[3:0], 8'hA5 ^ i[7:0]);
			if (i != 7) rdc(i[3:0], 8'hA5 ^ i[7:0]);
		end
		wr(4'hF, 8'h5A);
		rdc(4'hF, 8'h00);
		wr(4'h9, 8'h33);
		rdc(4'h9, 8'h00);
		// Area 1 SRAM, area 2 DRAM with one program wait, 2-Mbyte areas.
		wr(OFS_AREA_BUS_WIDTH, 8'hF9);
		wr(OFS_AREA_ACCESS_STATE, 8'h02);
		wr(OFS_WAIT_CTRL_LOW, 8'h13);
		wr(OFS_BUS_CTRL_LOW, 8'h04);
		wr(OFS_BUS_CTRL_HIGH, {5'h00, DRAM_SPACE_AREA2});
		wr(OFS_MEMORY_CTRL, 8'h44);
		wr(OFS_DRAM_CTRL, 8'h00);
		dec(24'h200000, 1, 0, 1, 1, 2'h0);
		dec(24'h23FFFF, 1, 0, 1, 1, 2'h0);
		dec(24'h1FFFFF, 0, 0, 0, 0, 2'h3);
		dec(24'h400000, 0, 1, 1, 0, 2'h1);
		dec(24'h47FFFF, 0, 1, 1, 0, 2'h1);
		wr(OFS_AREA_BUS_WIDTH, 8'hFF);
		wr(OFS_AREA_ACCESS_STATE, 8'h00);
		dec(24'h200000, 1, 0, 0, 0, 2'h0);
		dec(24'h400000, 0, 1, 0, 0, 2'h1);
		dec(24'h240000, 0, 0, 0, 0, 2'h0);
		dec(24'h480000, 0, 0, 0, 0, 2'h1);
		wr(OFS_BUS_CTRL_LOW, 8'h00);
		dec(24'h200000, 0, 0, 0, 0, 2'h3);
		for (int m = 0; m < 8; m++)
		begin
			wr(OFS_BUS_CTRL_LOW, {3'h0, m[2], 4'h4});
			cas_active_i <= 1'b1;
			byte_hi_i    <= m[1];
			byte_lo_i    <= m[0];
			settle();
			chk(upper_cas_n_o, !m[1]);
			chk(lws_is_cas_o, m[2]);
			chk(lower_column_strobe_n_o, m[2] || !m[0]);
			chk(lower_write_strobe_cas_n_o, !m[2] || !m[0]);
		end
		@(posedge sys_clk_i);
		cas_active_i <= 1'b0;
		settle();
		chk({upper_cas_n_o, lower_write_strobe_cas_n_o}, 2'h3);
		chk(precharge_two_o, 1'b0);
		chk(fast_page_o, 1'b1);
		chk(row_down_o, 1'b0);
		chk(row_shift_o, 4'h9);
		chk(refresh_wait_o, 2'h0);
		wr(OFS_MEMORY_CTRL, 8'h20);
		settle();
		chk(row_down_o, 1'b0);
		wr(OFS_BUS_CTRL_LOW, 8'h04);
		settle();
		chk(row_down_o, 1'b1);
		wr(OFS_MEMORY_CTRL, 8'h83);
		settle();
		chk({precharge_two_o, fast_page_o, row_shift_o}, 6'h28);
		chk(refresh_wait_o, 2'h0);
		wr(OFS_DRAM_CTRL, 8'h40);
		settle();
		chk(refresh_wait_o, 2'h3);
		wr(OFS_MEMORY_CTRL, 8'h44);
		wr(OFS_REFRESH_CONST, 8'h4F);
		wr(OFS_DRAM_CTRL, 8'h81);
		wait_lvl(1'b1, t0);
		chk(cmp_irq_o, 1'b0);
		dly <= 4'h9;
		rdc(OFS_DRAM_CTRL, 8'h91);
		wait_lvl(1'b0, t1);
		wait_lvl(1'b1, t1);
		chk(32'(t1 - t0), 32'd160);
		wr(OFS_DRAM_CTRL, 8'h89);
		rdc(OFS_DRAM_CTRL, 8'h89);
		wait_lvl(1'b0, t1);
		wait_lvl(1'b1, t1);
		chk(cmp_irq_o, 1'b1);
		end_sim();
	end
endmodule
`default_nettype wire
